// file: rtl/audio_src_irq_cfg.svh
// constants for the audio converter interrupt status block
`ifndef AUDIO_SRC_IRQ_CFG_SVH
`define AUDIO_SRC_IRQ_CFG_SVH

// ----------------------------------------------------------------------
// control port addresses
// ----------------------------------------------------------------------
`define INT1_STATUS_ADDR   7'h07
`define INT2_STATUS_ADDR   7'h08
`define INT1_MASK_ADDR     7'h09
`define INT1_MODE_HI_ADDR  7'h0a
`define INT1_MODE_LO_ADDR  7'h0b
`define INT2_MASK_ADDR     7'h0c
`define INT2_MODE_HI_ADDR  7'h0d
`define INT2_MODE_LO_ADDR  7'h0e
`define RX_ERROR_ADDR      7'h10

// ----------------------------------------------------------------------
// reset values and implemented bits
// ----------------------------------------------------------------------
`define IRQ_REG_RESET      8'h00
`define INT1_IMPL_BITS     8'hff
`define INT2_IMPL_BITS     8'h3f
`define RX_ERR_RESET       7'h00

// ----------------------------------------------------------------------
// field positions, first status register
// ----------------------------------------------------------------------
`define BIT_TX_SLIP        7
`define BIT_OUT_SLIP       6
`define BIT_RATE_RANGE     5
`define BIT_LEFT_OVR       4
`define BIT_RIGHT_OVR      3
`define BIT_CS_D_TO_E      2
`define BIT_CS_E_TO_F      1
`define BIT_RX_ERROR       0

// ----------------------------------------------------------------------
// field positions, second status register
// ----------------------------------------------------------------------
`define BIT_VARI_OVF       5
`define BIT_UNLOCK         4
`define BIT_UD_D_TO_E      3
`define BIT_UD_E_TO_F      2
`define BIT_QCHAN          1
`define BIT_UFIFO_OVW      0

// ----------------------------------------------------------------------
// event mode codes (msb register bit, lsb register bit)
// ----------------------------------------------------------------------
`define MODE_RISING        2'b00
`define MODE_FALLING       2'b01
`define MODE_LEVEL         2'b10

// ----------------------------------------------------------------------
// converter sample widths
// ----------------------------------------------------------------------
`define RAW_WIDTH          28
`define SAMPLE_WIDTH       24

`endif

// file: rtl/audio_src_irq_pkg.sv
// types shared by the audio converter interrupt status block
package audio_src_irq_pkg;

   typedef logic [7:0] reg_byte_t;

   // event sources that feed the second status register
   typedef struct packed {
      logic vari_fifo_write;      // write attempt into the varispeed buffer
      logic vari_fifo_full;       // varispeed buffer has no free entry
      logic src_tracking;         // converter still following a rate change
      logic ud_d_to_e_busy;       // user-data D to E copy in progress
      logic ud_e_to_f_busy;       // user-data E to F copy in progress
      logic ud_block_mode;        // user data handled in block mode
      logic qchan_new;            // new Q-channel block readable
      logic ubit_fifo_write;      // write into the user-bit FIFO
      logic ubit_fifo_full;       // oldest user-bit entry not yet consumed
   } src_two_s;

   // event sources that feed the first status register
   typedef struct packed {
      logic tx_slip;
      logic out_slip;
      logic rate_range;
      logic cs_d_to_e_busy;       // channel-status D to E copy in progress
      logic cs_e_to_f_busy;       // channel-status E to F copy in progress
   } src_one_s;

endpackage : audio_src_irq_pkg

// file: rtl/audio_src_interrupt_status.sv
// interrupt status registers, event detection and output saturation
//
// Summary of operation
// [RULE_01] right-channel over-range event raised when the right result leaves range
// [RULE_02] over-range output samples clip to positive or negative full scale
// [RULE_03] channel-status D-to-E event source true while that copy runs
// [RULE_04] channel-status E-to-F event source true while that copy runs
// [RULE_05] any receiver error sets the event; cause kept in its own register
// [RULE_06] second status register at address 8, read only, top two bits zero
// [RULE_07] a status bit reads one if its event happened since the last read
// [RULE_08] reading clears all bits except level-mode bits whose source persists
// [RULE_09] a masked status bit always reads zero
// [RULE_10] second status register is zero after reset
// [RULE_11] varispeed overflow event raised when the converter buffer overflows
// [RULE_12] overflow caught when writes hit a full buffer as input rate drops
// [RULE_13] user-data E-to-F source true during that copy, block mode only
// [RULE_14] user-bit FIFO overwrite event raised when an unread entry is overwritten
// [RULE_15] user-data D-to-E source true during that copy, block mode only
// [RULE_16] unlock event while converter tracks a rate change; Q event on new block
// [RULE_17] mask one lets an event reach pin and status; mask zero blocks both
// [RULE_18] two-bit mode per event: 00 rising, 01 falling, 10 level, 11 reserved
`include "audio_src_irq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module audio_src_interrupt_status (
   input  wire logic                             sys_clk,
   input  wire logic                             rst_n,
   // control port register access
   input  wire logic [6:0]                       reg_addr,
   input  wire logic                             reg_rd,
   input  wire logic                             reg_wr,
   input  wire logic [7:0]                       reg_wdata,
   output logic      [7:0]                       reg_rdata,

   // converter results, one word per channel
   input  wire logic                             conv_valid,
   input  wire logic signed [`RAW_WIDTH-1:0]     conv_left_raw,
   input  wire logic signed [`RAW_WIDTH-1:0]     conv_right_raw,
   output logic signed [`SAMPLE_WIDTH-1:0]       sample_left,
   output logic signed [`SAMPLE_WIDTH-1:0]       sample_right,
   output logic                                  sample_valid,

   // event sources from the rest of the device
   input  wire audio_src_irq_pkg::src_one_s      src_one,
   input  wire audio_src_irq_pkg::src_two_s      src_two,
   input  wire logic [6:0]                       rx_err_cause,

   // interrupt pin, high while any unmasked status bit is set
   output logic                                  irq
);

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------

   // true when the raw result does not fit the output sample width
   function automatic logic out_of_range(input logic signed [`RAW_WIDTH-1:0] raw);
      logic [`RAW_WIDTH-`SAMPLE_WIDTH:0] top;
      top = raw[`RAW_WIDTH-1:`SAMPLE_WIDTH-1];
      // fits only if all top bits agree
      out_of_range = !((&top) || !(|top));
   endfunction : out_of_range

   // clip to full scale on the side of the sign, else keep the low bits
   function automatic logic [`SAMPLE_WIDTH-1:0] saturate(
      input logic signed [`RAW_WIDTH-1:0] raw);
      logic [`SAMPLE_WIDTH-1:0] res;
      res = raw[`SAMPLE_WIDTH-1:0];
      if (out_of_range(raw)) begin
         res = raw[`RAW_WIDTH-1] ? {1'b1, {(`SAMPLE_WIDTH-1){1'b0}}}
                                 : {1'b0, {(`SAMPLE_WIDTH-1){1'b1}}};
      end
      saturate = res;
   endfunction : saturate

   // per-bit event from the source, its previous value and the mode code
   function automatic logic [7:0] detect_events(
      input logic [7:0] src,
      input logic [7:0] prev,
      input logic [7:0] mode_hi,
      input logic [7:0] mode_lo);
      logic [7:0] ev;
      ev = 8'h00;
      for (int i = 0; i < 8; i++) begin
         case ({mode_hi[i], mode_lo[i]})
            `MODE_RISING:  ev[i] = src[i] & ~prev[i];
            `MODE_FALLING: ev[i] = ~src[i] & prev[i];
            `MODE_LEVEL:   ev[i] = src[i];
            default:       ev[i] = 1'b0;   // reserved code raises nothing
         endcase
      end
      detect_events = ev;
   endfunction : detect_events

   // ----------------------------------------------------------------------
   // register file state
   // ----------------------------------------------------------------------
   audio_src_irq_pkg::reg_byte_t status   [2];
   audio_src_irq_pkg::reg_byte_t mask     [2];
   audio_src_irq_pkg::reg_byte_t mode_hi  [2];
   audio_src_irq_pkg::reg_byte_t mode_lo  [2];
   audio_src_irq_pkg::reg_byte_t src_now  [2];
   audio_src_irq_pkg::reg_byte_t src_prev [2];
   audio_src_irq_pkg::reg_byte_t events   [2];

   logic [7:0]                   impl_bits [2];
   logic [6:0]                   rx_error;

   logic                         status_rd [2];
   logic                         left_ovr;
   logic                         right_ovr;
   logic                         rx_err_any;

   assign impl_bits[0] = `INT1_IMPL_BITS;
   assign impl_bits[1] = `INT2_IMPL_BITS;

   // ----------------------------------------------------------------------
   // converter output clipping
   // ----------------------------------------------------------------------

   // over-range detection on each channel result
   assign left_ovr  = conv_valid & out_of_range(conv_left_raw);
   // [RULE_01] right over-range detect
   assign right_ovr = conv_valid & out_of_range(conv_right_raw);

   // [RULE_02] clip to full scale
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_left  <= '0;
         sample_right <= '0;
         sample_valid <= 1'b0;
      end else begin
         sample_valid <= conv_valid;
         if (conv_valid) begin
            sample_left  <= saturate(conv_left_raw);
            sample_right <= saturate(conv_right_raw);
         end
      end
   end

   // ----------------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------------

   // [RULE_05] any receiver error
   assign rx_err_any = |rx_err_cause;

   // first status register sources, one bit per field
   always_comb begin
      src_now[0]                  = 8'h00;
      src_now[0][`BIT_TX_SLIP]    = src_one.tx_slip;
      src_now[0][`BIT_OUT_SLIP]   = src_one.out_slip;
      src_now[0][`BIT_RATE_RANGE] = src_one.rate_range;
      src_now[0][`BIT_LEFT_OVR]   = left_ovr;
      src_now[0][`BIT_RIGHT_OVR]  = right_ovr;
      // [RULE_03] cs D-to-E source
      src_now[0][`BIT_CS_D_TO_E]  = src_one.cs_d_to_e_busy;
      // [RULE_04] cs E-to-F source
      src_now[0][`BIT_CS_E_TO_F]  = src_one.cs_e_to_f_busy;
      src_now[0][`BIT_RX_ERROR]   = rx_err_any;
   end

   // second status register sources, top two bits held at zero
   always_comb begin
      src_now[1]                 = 8'h00;
      // [RULE_11] buffer overflow source
      // [RULE_12] write into full buffer
      src_now[1][`BIT_VARI_OVF]  = src_two.vari_fifo_write & src_two.vari_fifo_full;
      // [RULE_16] unlock while tracking
      src_now[1][`BIT_UNLOCK]    = src_two.src_tracking;
      // [RULE_15] ud D-to-E in block mode
      src_now[1][`BIT_UD_D_TO_E] = src_two.ud_d_to_e_busy & src_two.ud_block_mode;
      // [RULE_13] ud E-to-F in block mode
      src_now[1][`BIT_UD_E_TO_F] = src_two.ud_e_to_f_busy & src_two.ud_block_mode;
      // [RULE_16] new Q-channel block
      src_now[1][`BIT_QCHAN]     = src_two.qchan_new;
      // [RULE_14] unread entry overwritten
      src_now[1][`BIT_UFIFO_OVW] = src_two.ubit_fifo_write & src_two.ubit_fifo_full;
   end

   // ----------------------------------------------------------------------
   // status registers
   // ----------------------------------------------------------------------

   assign status_rd[0] = reg_rd && (reg_addr == `INT1_STATUS_ADDR);

   // [RULE_06] second status at address 8
   assign status_rd[1] = reg_rd && (reg_addr == `INT2_STATUS_ADDR);

   genvar g;

   generate
      for (g = 0; g < 2; g++) begin : gen_status
         // [RULE_18] mode-coded detection
         assign events[g] = detect_events(src_now[g], src_prev[g], mode_hi[g], mode_lo[g]);

         // previous source value for edge modes
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               src_prev[g] <= `IRQ_REG_RESET;
            end else begin
               src_prev[g] <= src_now[g];
            end
         end

         // sticky bits; an event in the read cycle survives the clear
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               // [RULE_10] zero after reset
               status[g] <= `IRQ_REG_RESET;
            end else if (status_rd[g]) begin
               // [RULE_08] clear on read, level sources hold
               // [RULE_17] mask gates the status
               status[g] <= events[g] & mask[g] & impl_bits[g];
            end else begin
               // [RULE_07] set once, hold until read
               // [RULE_09] masked bits forced to zero
               status[g] <= (status[g] | events[g]) & mask[g] & impl_bits[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // mask and mode registers
   // ----------------------------------------------------------------------

   // software writes; unimplemented bits of the second set stay zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask[0]    <= `IRQ_REG_RESET;
         mask[1]    <= `IRQ_REG_RESET;
         mode_hi[0] <= `IRQ_REG_RESET;
         mode_hi[1] <= `IRQ_REG_RESET;
         mode_lo[0] <= `IRQ_REG_RESET;
         mode_lo[1] <= `IRQ_REG_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `INT1_MASK_ADDR:    mask[0]    <= reg_wdata;
            `INT1_MODE_HI_ADDR: mode_hi[0] <= reg_wdata;
            `INT1_MODE_LO_ADDR: mode_lo[0] <= reg_wdata;
            `INT2_MASK_ADDR:    mask[1]    <= reg_wdata & `INT2_IMPL_BITS;
            `INT2_MODE_HI_ADDR: mode_hi[1] <= reg_wdata & `INT2_IMPL_BITS;
            `INT2_MODE_LO_ADDR: mode_lo[1] <= reg_wdata & `INT2_IMPL_BITS;
            default: ;                  // status and other addresses ignore writes
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // receiver error cause register
   // ----------------------------------------------------------------------

   // [RULE_05] cause bits sticky until read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_error <= `RX_ERR_RESET;
      end else if (reg_rd && (reg_addr == `RX_ERROR_ADDR)) begin
         rx_error <= rx_err_cause;     // new cause in the read cycle is kept
      end else begin
         rx_error <= rx_error | rx_err_cause;
      end
   end

   // ----------------------------------------------------------------------
   // read data and interrupt pin
   // ----------------------------------------------------------------------

   // read data captured one cycle after the strobe, pre-clear value
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `INT1_STATUS_ADDR:  reg_rdata <= status[0];
            // [RULE_06] read-only, top bits zero
            `INT2_STATUS_ADDR:  reg_rdata <= status[1] & `INT2_IMPL_BITS;
            `INT1_MASK_ADDR:    reg_rdata <= mask[0];
            `INT1_MODE_HI_ADDR: reg_rdata <= mode_hi[0];
            `INT1_MODE_LO_ADDR: reg_rdata <= mode_lo[0];
            `INT2_MASK_ADDR:    reg_rdata <= mask[1];
            `INT2_MODE_HI_ADDR: reg_rdata <= mode_hi[1];
            `INT2_MODE_LO_ADDR: reg_rdata <= mode_lo[1];
            `RX_ERROR_ADDR:     reg_rdata <= {1'b0, rx_error};
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

   // registered so the pin cannot glitch
   // [RULE_17] pin follows unmasked status
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (|status[0]) | (|status[1]);
      end
   end

endmodule : audio_src_interrupt_status

`default_nettype wire

// file: bench/audio_src_irq_checker.sv
// port checks for the audio converter interrupt status block
`include "audio_src_irq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module audio_src_irq_checker (
   input wire logic                         sys_clk,
   input wire logic                         rst_n,
   input wire logic [6:0]                   reg_addr,
   input wire logic                         reg_rd,
   input wire logic                         reg_wr,
   input wire logic [7:0]                   reg_wdata,
   input wire logic [7:0]                   reg_rdata,
   input wire logic                         conv_valid,
   input wire logic signed [`RAW_WIDTH-1:0] conv_right_raw,
   input wire logic signed [`SAMPLE_WIDTH-1:0] sample_right,
   input wire logic                         irq
);
   // ---------------------------------------------------------------
   // helper state
   // ---------------------------------------------------------------
   logic [7:0]  mask_one;
   logic [7:0]  mask_two;
   logic [7:0]  mask_two_prev;
   logic [1:0]  zero_cnt;
   logic [23:0] right_low;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   assign right_low = conv_right_raw[23:0];

   // shadow copies of both mask registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_one      <= 8'h00;
         mask_two      <= 8'h00;
         mask_two_prev <= 8'h00;
      end else begin
         mask_two_prev <= mask_two;
         if (reg_wr && reg_addr == `INT1_MASK_ADDR) begin
            mask_one <= reg_wdata;
         end
         if (reg_wr && reg_addr == `INT2_MASK_ADDR) begin
            mask_two <= reg_wdata;
         end
      end
   end

   // cycles since every mask went to zero, saturating
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_cnt <= 2'h3;
      end else if (mask_one != 8'h00 || mask_two != 8'h00) begin
         zero_cnt <= 2'h0;
      end else if (zero_cnt != 2'h3) begin
         zero_cnt <= zero_cnt + 2'h1;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_sat_pos;
      conv_valid && conv_right_raw > 28'sh07fffff |=> sample_right == 24'h7fffff;
   endproperty
   a_sat_pos: assert property (p_sat_pos)
      else $error("right sample not clipped to positive full scale");

   property p_sat_neg;
      conv_valid && conv_right_raw < -28'sh0800000 |=> sample_right == 24'h800000;
   endproperty
   a_sat_neg: assert property (p_sat_neg)
      else $error("right sample not clipped to negative full scale");

   property p_sat_pass;
      conv_valid && conv_right_raw <= 28'sh07fffff && conv_right_raw >= -28'sh0800000
         |=> sample_right == $past(right_low);
   endproperty
   a_sat_pass: assert property (p_sat_pass)
      else $error("in-range right sample altered");

   property p_top_zero;
      reg_rd && reg_addr == `INT2_STATUS_ADDR |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_top_zero: assert property (p_top_zero)
      else $error("status two top bits not zero");

   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");

   property p_masked;
      reg_rd && reg_addr == `INT2_STATUS_ADDR && mask_two == mask_two_prev
         |=> (reg_rdata & ~mask_two) == 8'h00;
   endproperty
   a_masked: assert property (p_masked)
      else $error("masked status bit read as one");

   property p_irq_masked;
      zero_cnt == 2'h3 |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("irq high with every event masked");

   property p_reset_zero;
      $rose(rst_n) |-> irq == 1'b0 && reg_rdata == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("outputs not zero after reset");

   c_irq: cover property ($rose(irq));
   c_sat: cover property (conv_valid && conv_right_raw > 28'sh07fffff);
   c_read_set: cover property (reg_rd && reg_addr == `INT2_STATUS_ADDR ##1 reg_rdata != 8'h00);
endmodule : audio_src_irq_checker

bind audio_src_interrupt_status audio_src_irq_checker u_audio_src_irq_checker (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .conv_valid(conv_valid), .conv_right_raw(conv_right_raw),
   .sample_right(sample_right), .irq(irq));

`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the audio converter interrupt status block
`include "audio_src_irq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic                            sys_clk;
   logic                            rst_n;
   logic [6:0]                      reg_addr;
   logic                            reg_rd;
   logic                            reg_wr;
   logic [7:0]                      reg_wdata;
   logic [7:0]                      reg_rdata;
   logic                            conv_valid;
   logic signed [`RAW_WIDTH-1:0]    conv_left_raw;
   logic signed [`RAW_WIDTH-1:0]    conv_right_raw;
   logic signed [`SAMPLE_WIDTH-1:0] sample_left;
   logic signed [`SAMPLE_WIDTH-1:0] sample_right;
   logic                            sample_valid;
   audio_src_irq_pkg::src_one_s     src_one;
   audio_src_irq_pkg::src_two_s     src_two;
   logic [6:0]                      rx_err_cause;
   logic                            irq;
   int                              err_total;
   int                              check_count;
   logic [7:0]                      rd_val;
   logic [5:0]                      mask;
   logic [3:0]                      mode_tbl [4];
   logic [8:0]                      gate_src [2];
   logic [5:0]                      gate_exp [2];
   logic signed [`RAW_WIDTH-1:0]    corner [4];
   logic signed [`RAW_WIDTH-1:0]    raw;
   logic [23:0]                     r24;
   logic [6:0]                      cause;

   audio_src_interrupt_status u_audio_src_interrupt_status (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .conv_valid(conv_valid), .conv_left_raw(conv_left_raw),
      .conv_right_raw(conv_right_raw), .sample_left(sample_left),
      .sample_right(sample_right), .sample_valid(sample_valid), .src_one(src_one),
      .src_two(src_two), .rx_err_cause(rx_err_cause), .irq(irq));

   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // tasks and functions
   // ---------------------------------------------------------------
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chk24(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk24

   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : idle

   // one write strobe, then a quiet cycle
   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      @(negedge sys_clk);
   endtask : reg_write

   // read data lands one cycle after the strobe edge
   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d      = reg_rdata;
      @(negedge sys_clk);
   endtask : reg_read

   task automatic set_modes(input logic [1:0] m);
      reg_write(`INT2_MODE_HI_ADDR, {8{m[1]}});
      reg_write(`INT2_MODE_LO_ADDR, {8{m[0]}});
   endtask : set_modes

   function automatic logic [23:0] sat(input logic signed [27:0] v);
      if (v > 28'sh07fffff) return 24'h7fffff;
      if (v < -28'sh0800000) return 24'h800000;
      return v[23:0];
   endfunction : sat

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0; reg_addr = 7'h00; reg_rd = 1'b0; reg_wr = 1'b0; reg_wdata = 8'h00;
      conv_valid = 1'b0; conv_left_raw = '0; conv_right_raw = '0;
      src_one = '0; src_two = '0; rx_err_cause = 7'h00; err_total = 0; check_count = 0;
      mode_tbl = '{4'b0001, 4'b0100, 4'b0111, 4'b0000};
      gate_src = '{9'h176, 9'h0b9};
      gate_exp = '{6'h12, 6'h0c};
      corner = '{28'sh0800000, 28'sh07fffff, -28'sh0800000, -28'sh0800001};
      void'($urandom(13));
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      reg_read(`INT2_STATUS_ADDR, rd_val);
      chk8("status two reset", 8'h00, rd_val);
      chk8("irq reset", 8'h00, {7'h00, irq});
      reg_write(`INT2_STATUS_ADDR, 8'hff);
      reg_read(`INT2_STATUS_ADDR, rd_val);
      chk8("status two read only", 8'h00, rd_val);
      reg_read(7'h20, rd_val);
      chk8("unmapped read", 8'h00, rd_val);
      reg_write(`INT2_MASK_ADDR, 8'hff);
      reg_read(`INT2_MASK_ADDR, rd_val);
      chk8("mask two", 8'h3f, rd_val);
      // each mode code: arrival, held, removal, cleared
      for (int m = 0; m < 4; m++) begin
         mask = (m == 2) ? 6'h15 : 6'($urandom);
         reg_write(`INT2_MASK_ADDR, {2'b00, mask});
         set_modes(2'(m));
         reg_read(`INT2_STATUS_ADDR, rd_val);
         src_two = 9'h1ff;
         idle(2 + $urandom_range(2));
         chk8("irq", {7'h00, mode_tbl[m][0] & (mask != 6'h00)}, {7'h00, irq});
         for (int k = 0; k < 4; k++) begin
            if (k == 2) begin
               src_two = 9'h000;
               idle(2);
            end
            reg_read(`INT2_STATUS_ADDR, rd_val);
            chk8("status two", {2'b00, mask & {6{mode_tbl[m][k]}}}, rd_val);
         end
      end
      // source qualifiers: write needs full, user data needs block mode
      reg_write(`INT2_MASK_ADDR, 8'h3f);
      set_modes(2'b00);
      for (int g = 0; g < 2; g++) begin
         reg_read(`INT2_STATUS_ADDR, rd_val);
         src_two = gate_src[g];
         idle(3);
         src_two = 9'h000;
         idle(2);
         reg_read(`INT2_STATUS_ADDR, rd_val);
         chk8("gated sources", {2'b00, gate_exp[g]}, rd_val);
      end
      // converter clipping with first register events
      reg_write(`INT1_MASK_ADDR, 8'hff);
      reg_read(`INT1_STATUS_ADDR, rd_val);
      cause = 7'($urandom_range(127, 1));
      rx_err_cause = cause;
      src_one = 5'b00011;
      conv_valid = 1'b1;
      for (int i = 0; i < 24; i++) begin
         r24 = 24'($urandom);
         raw = (i < 4) ? corner[i] : ((i % 2) ? 28'($urandom) : {{4{r24[23]}}, r24});
         conv_right_raw = raw;
         r24 = 24'($urandom);
         conv_left_raw = {{4{r24[23]}}, r24};
         @(negedge sys_clk);
         chk24("right sample", sat(raw), sample_right);
         chk24("left sample", r24, sample_left);
         chk8("valid", 8'h01, {7'h00, sample_valid});
      end
      conv_valid = 1'b0;
      src_one = '0;
      rx_err_cause = 7'h00;
      idle(2);
      chk8("valid idle", 8'h00, {7'h00, sample_valid});
      reg_read(`INT1_STATUS_ADDR, rd_val);
      chk8("status one", 8'h0f, rd_val);
      reg_read(`RX_ERROR_ADDR, rd_val);
      chk8("receiver cause", {1'b0, cause}, rd_val);
      tally_and_finish();
   end

   // hang guard, far beyond the fewer than two hundred cycles used
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      tally_and_finish();
   end
endmodule : testbench

`default_nettype wire
